// *** core/ossm_pkg.sv ***
package ossm_pkg;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned STRB_W   = 4;
  localparam int unsigned NUM_SRC  = 10;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned SEL_W    = 4;

  // register byte addresses
  localparam logic [7:0] OFS_SELECT   = 8'h00;
  localparam logic [7:0] OFS_POLARITY = 8'h04;
  localparam logic [7:0] OFS_MODE     = 8'h08;
  localparam logic [7:0] OFS_LEVEL    = 8'h0c;

  // field layout: select word holds one nibble each for channels 2 to 4, channel 2 lowest at bit 4
  localparam int unsigned SEL_CH2_LSB = 4;
  localparam int unsigned SEL_CH3_LSB = 8;
  localparam int unsigned SEL_CH4_LSB = 12;
  localparam int unsigned LVL_SRC_LSB = 4;

  // reset values
  localparam logic [3:0] SEL_CH2_RST = 4'h1;
  localparam logic [3:0] SEL_CH3_RST = 4'h2;
  localparam logic [3:0] SEL_CH4_RST = 4'h3;
  localparam logic [3:0] POL_RST     = 4'h0;
  localparam logic [1:0] MODE_RST    = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SRC_ALARM      = 4'h0,
    SRC_POS_DONE   = 4'h1,
    SRC_INDEX      = 4'h2,
    SRC_BRAKE      = 4'h3,
    SRC_READY      = 4'h4,
    SRC_SPEED_OK   = 4'h5,
    SRC_ROTATION   = 4'h6,
    SRC_TORQUE_LIM = 4'h7,
    SRC_ZERO_SPEED = 4'h8,
    SRC_CAUTION    = 4'h9
  } ossm_src_e;

  typedef enum logic [1:0] {
    MODE_POSITION = 2'h0,
    MODE_SPEED    = 2'h1,
    MODE_TORQUE   = 2'h2
  } ossm_mode_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_RESP = 2'h1
  } ossm_bus_e;

  typedef struct packed {
    logic [3:0] sel;
    logic       pol;
  } ossm_cfg_s;

  function automatic logic [31:0] merge_strobe(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic sel_is_index(input logic [3:0] sel);
    return sel == SRC_INDEX;
  endfunction

endpackage

// *** core/ossm_mode_gate.sv ***
`timescale 1ns/10ps
`default_nettype none

module ossm_mode_gate (
  input  wire logic [ossm_pkg::NUM_SRC-1:0] raw_src,
  input  wire logic [1:0]                   mode,
  output logic      [ossm_pkg::NUM_SRC-1:0] gated_src
);

  // sources the present control mode does not produce stay inactive
  always_comb begin
    gated_src = raw_src;
    if (mode != ossm_pkg::MODE_POSITION) begin
      gated_src[ossm_pkg::SRC_POS_DONE] = 1'b0;   // see RQ5
    end
    if (mode != ossm_pkg::MODE_SPEED) begin
      gated_src[ossm_pkg::SRC_SPEED_OK] = 1'b0;   // see RQ5
    end
  end

endmodule

`default_nettype wire

// *** core/ossm_chan_mux.sv ***
`timescale 1ns/10ps
`default_nettype none

module ossm_chan_mux (
  input  wire ossm_pkg::ossm_cfg_s          cfg,
  input  wire logic [ossm_pkg::NUM_SRC-1:0] src,
  input  wire logic                         index_taken,
  output logic                              level
);

  logic active;
  logic is_index;

  always_comb begin
    is_index = ossm_pkg::sel_is_index(cfg.sel);
    active   = 1'b0;
    // alarm is never routed here; codes above nine give an idle output
    if (cfg.sel != ossm_pkg::SRC_ALARM &&
        cfg.sel <= ossm_pkg::SRC_CAUTION) begin                 // see RQ1
      active = src[cfg.sel];                                   // see RQ2
    end
    if (is_index && index_taken) begin
      active = 1'b0;                                           // see RQ7
    end
    if (is_index) begin
      level = ~active;                                         // see RQ6
    end else begin
      level = cfg.pol ? active : ~active;                      // see RQ4
    end
  end

endmodule

`default_nettype wire

// *** core/ossm_top.sv ***
// Notes on behaviour
// RQ1: channel 1 always carries alarm; alarm never reaches channels 2 to 4.
// RQ2: channels 2 to 4 pick one of nine status sources (codes 1 to 9) by a code.
// RQ3: after reset channel 2 is position done, 3 index, 4 brake release.
// RQ4: polarity 0 makes low active on channels 2-4; channel 1 is opposite.
// RQ5: a source the control mode does not produce stays inactive.
// RQ6: a channel carrying the index pulse ignores its polarity bit.
// RQ7: if two channels pick the index pulse, only the higher one drives it.
// RQ8: active alarm means an alarm is present, inactive means none.
// RQ9: channel levels are registered; setting changes act next clock.
`timescale 1ns/10ps
`default_nettype none

module ossm_top (
  input  wire logic                          CLOCK,
  input  wire logic                          SYS_RST,
  input  wire logic [ossm_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire logic [ossm_pkg::DATA_W-1:0]   S_AXI_WDATA,
  input  wire logic [ossm_pkg::STRB_W-1:0]   S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic [1:0]                         S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  input  wire logic [ossm_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic [ossm_pkg::DATA_W-1:0]        S_AXI_RDATA,
  output logic [1:0]                         S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY,
  input  wire logic [ossm_pkg::NUM_SRC-1:0]  STATUS_SRC,
  output logic                               OUT_CHAN_1,
  output logic                               OUT_CHAN_2,
  output logic                               OUT_CHAN_3,
  output logic                               OUT_CHAN_4
);

  ////////////////////////////////////////////////////////////////////////////

  // write channel state
  ossm_pkg::ossm_bus_e          wr_state;
  ossm_pkg::ossm_bus_e          next_wr_state;
  logic                         aw_held;
  logic                         next_aw_held;
  logic                         w_held;
  logic                         next_w_held;
  logic [ossm_pkg::ADDR_W-1:0]  wr_addr;
  logic [ossm_pkg::ADDR_W-1:0]  next_wr_addr;
  logic [ossm_pkg::DATA_W-1:0]  wr_data;
  logic [ossm_pkg::DATA_W-1:0]  next_wr_data;
  logic [ossm_pkg::STRB_W-1:0]  wr_strb;
  logic [ossm_pkg::STRB_W-1:0]  next_wr_strb;
  logic                         awready;
  logic                         next_awready;
  logic                         wready;
  logic                         next_wready;
  logic [1:0]                   bresp;
  logic [1:0]                   next_bresp;

  // read channel state
  ossm_pkg::ossm_bus_e          rd_state;
  ossm_pkg::ossm_bus_e          next_rd_state;
  logic                         arready;
  logic                         next_arready;
  logic [ossm_pkg::DATA_W-1:0]  rdata;
  logic [ossm_pkg::DATA_W-1:0]  next_rdata;
  logic [1:0]                   rresp;
  logic [1:0]                   next_rresp;

  // configuration
  logic [3:0]                   sel2;
  logic [3:0]                   next_sel2;
  logic [3:0]                   sel3;
  logic [3:0]                   next_sel3;
  logic [3:0]                   sel4;
  logic [3:0]                   next_sel4;
  logic [3:0]                   pol;
  logic [3:0]                   next_pol;
  logic [1:0]                   mode;
  logic [1:0]                   next_mode;

  // output levels
  logic [ossm_pkg::NUM_CHAN-1:0] lvl;
  logic [ossm_pkg::NUM_CHAN-1:0] next_lvl;
  logic [ossm_pkg::NUM_SRC-1:0]  gated_src;
  logic                          lvl2;
  logic                          lvl3;
  logic                          lvl4;
  logic [31:0]                   wr_merged;
  logic [31:0]                   sel_word;
  logic [31:0]                   pol_word;
  logic [31:0]                   mode_word;
  logic [31:0]                   lvl_word;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    sel_word = 32'h0000_0000;
    sel_word[ossm_pkg::SEL_CH2_LSB +: 4] = sel2;
    sel_word[ossm_pkg::SEL_CH3_LSB +: 4] = sel3;
    sel_word[ossm_pkg::SEL_CH4_LSB +: 4] = sel4;
    pol_word  = {28'h000_0000, pol};
    mode_word = {30'h0000_0000, mode};
    lvl_word  = 32'h0000_0000;
    lvl_word[3:0] = lvl;
    lvl_word[ossm_pkg::LVL_SRC_LSB +: ossm_pkg::NUM_SRC] = gated_src;
  end

  ////////////////////////////////////////////////////////////////////////////

  // address and data may arrive in either order; each is held until both are
  always_comb begin
    next_wr_state = wr_state;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    next_wr_strb  = wr_strb;
    next_bresp    = bresp;
    next_sel2     = sel2;
    next_sel3     = sel3;
    next_sel4     = sel4;
    next_pol      = pol;
    next_mode     = mode;
    wr_merged     = 32'h0000_0000;
    if (S_AXI_AWVALID && awready) begin
      next_aw_held = 1'b1;
      next_wr_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && wready) begin
      next_w_held  = 1'b1;
      next_wr_data = S_AXI_WDATA;
      next_wr_strb = S_AXI_WSTRB;
    end
    case (wr_state)
      ossm_pkg::BUS_IDLE: begin
        if (aw_held && w_held) begin
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
          next_wr_state = ossm_pkg::BUS_RESP;
          next_bresp    = ossm_pkg::RESP_OKAY;
          case (wr_addr)
            ossm_pkg::OFS_SELECT: begin
              wr_merged = ossm_pkg::merge_strobe(sel_word, wr_data, wr_strb);
              next_sel2 = wr_merged[ossm_pkg::SEL_CH2_LSB +: 4];  // see RQ9
              next_sel3 = wr_merged[ossm_pkg::SEL_CH3_LSB +: 4];  // see RQ9
              next_sel4 = wr_merged[ossm_pkg::SEL_CH4_LSB +: 4];  // see RQ9
            end
            ossm_pkg::OFS_POLARITY: begin
              wr_merged = ossm_pkg::merge_strobe(pol_word, wr_data, wr_strb);
              next_pol  = wr_merged[3:0];
            end
            ossm_pkg::OFS_MODE: begin
              wr_merged = ossm_pkg::merge_strobe(mode_word, wr_data, wr_strb);
              next_mode = wr_merged[1:0];
            end
            ossm_pkg::OFS_LEVEL: begin
              // read-only word: write is accepted and dropped
            end
            default: begin
              next_bresp = ossm_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      ossm_pkg::BUS_RESP: begin
        if (S_AXI_BREADY) begin
          next_wr_state = ossm_pkg::BUS_IDLE;
        end
      end
      default: begin
        next_wr_state = ossm_pkg::BUS_IDLE;
      end
    endcase
    // one write at a time: stop taking each half once that half is held
    next_awready = ~next_aw_held && (next_wr_state == ossm_pkg::BUS_IDLE);
    next_wready  = ~next_w_held && (next_wr_state == ossm_pkg::BUS_IDLE);
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_state <= ossm_pkg::BUS_IDLE;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
      wr_strb  <= '0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bresp    <= ossm_pkg::RESP_OKAY;
      sel2     <= ossm_pkg::SEL_CH2_RST;                      // see RQ3
      sel3     <= ossm_pkg::SEL_CH3_RST;                      // see RQ3
      sel4     <= ossm_pkg::SEL_CH4_RST;                      // see RQ3
      pol      <= ossm_pkg::POL_RST;
      mode     <= ossm_pkg::MODE_RST;
    end else begin
      wr_state <= next_wr_state;
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      wr_addr  <= next_wr_addr;
      wr_data  <= next_wr_data;
      wr_strb  <= next_wr_strb;
      awready  <= next_awready;
      wready   <= next_wready;
      bresp    <= next_bresp;
      sel2     <= next_sel2;
      sel3     <= next_sel3;
      sel4     <= next_sel4;
      pol      <= next_pol;
      mode     <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    case (rd_state)
      ossm_pkg::BUS_IDLE: begin
        if (S_AXI_ARVALID && arready) begin
          next_rd_state = ossm_pkg::BUS_RESP;
          next_rresp    = ossm_pkg::RESP_OKAY;
          case (S_AXI_ARADDR)
            ossm_pkg::OFS_SELECT:   next_rdata = sel_word;
            ossm_pkg::OFS_POLARITY: next_rdata = pol_word;
            ossm_pkg::OFS_MODE:     next_rdata = mode_word;
            ossm_pkg::OFS_LEVEL:    next_rdata = lvl_word;
            default: begin
              next_rdata = 32'h0000_0000;
              next_rresp = ossm_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      ossm_pkg::BUS_RESP: begin
        if (S_AXI_RREADY) begin
          next_rd_state = ossm_pkg::BUS_IDLE;
        end
      end
      default: begin
        next_rd_state = ossm_pkg::BUS_IDLE;
      end
    endcase
    next_arready = (next_rd_state == ossm_pkg::BUS_IDLE);
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_state <= ossm_pkg::BUS_IDLE;
      arready  <= 1'b0;
      rdata    <= '0;
      rresp    <= ossm_pkg::RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      arready  <= next_arready;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  ossm_mode_gate u_gate (
    .raw_src   (STATUS_SRC),
    .mode      (mode),
    .gated_src (gated_src)
  );

  // higher channels take the index pulse away from lower ones
  ossm_chan_mux u_chan2 (
    .cfg         ('{sel: sel2, pol: pol[1]}),
    .src         (gated_src),
    .index_taken (ossm_pkg::sel_is_index(sel3) ||
                  ossm_pkg::sel_is_index(sel4)),                // see RQ7
    .level       (lvl2)
  );

  ossm_chan_mux u_chan3 (
    .cfg         ('{sel: sel3, pol: pol[2]}),
    .src         (gated_src),
    .index_taken (ossm_pkg::sel_is_index(sel4)),                // see RQ7
    .level       (lvl3)
  );

  ossm_chan_mux u_chan4 (
    .cfg         ('{sel: sel4, pol: pol[3]}),
    .src         (gated_src),
    .index_taken (1'b0),
    .level       (lvl4)
  );

  ////////////////////////////////////////////////////////////////////////////

  // channel 1 is hard-wired to the alarm; its polarity sense is reversed
  always_comb begin
    next_lvl[0] = pol[0] ? ~gated_src[ossm_pkg::SRC_ALARM]
                         : gated_src[ossm_pkg::SRC_ALARM];   // see RQ1 see RQ4
    next_lvl[1] = lvl2;
    next_lvl[2] = lvl3;
    next_lvl[3] = lvl4;
  end

  // registered so the pins never glitch while settings change
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lvl <= 4'h0;
    end else begin
      lvl <= next_lvl;                                          // see RQ9
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    S_AXI_AWREADY = awready;
    S_AXI_WREADY  = wready;
    S_AXI_BVALID  = (wr_state == ossm_pkg::BUS_RESP);
    S_AXI_BRESP   = bresp;
    S_AXI_ARREADY = arready;
    S_AXI_RVALID  = (rd_state == ossm_pkg::BUS_RESP);
    S_AXI_RDATA   = rdata;
    S_AXI_RRESP   = rresp;
    OUT_CHAN_1    = lvl[0];                                     // see RQ8
    OUT_CHAN_2    = lvl[1];
    OUT_CHAN_3    = lvl[2];
    OUT_CHAN_4    = lvl[3];
  end

endmodule

`default_nettype wire

// *** verif/ossm_upper_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// upper controller: turns pin levels back into active flags
module ossm_upper_model (
  input  wire logic [3:0] level,
  input  wire logic [3:0] pol,
  output logic      [3:0] active
);
  // channel 1 reads high as active when its polarity bit is clear
  always_comb begin
    active[0]   = level[0] ^ pol[0];
    active[3:1] = ~(level[3:1] ^ pol[3:1]);
  end
endmodule

`default_nettype wire

// *** verif/ossm_top_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none

module ossm_top_monitor (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [9:0]  STATUS_SRC,
  input wire logic        OUT_CHAN_1
);
  logic       live;
  logic       upd;
  logic       pol1;
  logic       wd0;
  logic [7:0] wa;
  logic       exp1;

  assign exp1 = STATUS_SRC[0] ^ pol1;

  // shadow of polarity bit 0; strobes ignored, whole words assumed
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      live <= 1'b0;
      upd  <= 1'b0;
      pol1 <= 1'b0;
      wd0  <= 1'b0;
      wa   <= 8'h00;
    end else begin
      live <= 1'b1;
      upd  <= S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        wa  <= S_AXI_AWADDR;
        wd0 <= S_AXI_WDATA[0];
      end
      if (upd && wa == ossm_pkg::OFS_POLARITY) begin
        pol1 <= wd0;
      end
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  ch1_alarm_a: assert property (live |-> OUT_CHAN_1 == $past(exp1))
    else $error("channel 1 does not follow alarm");
  bv_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  rv_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
  ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("arready while rvalid");
  rd_lat_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID) else $error("read answer late");
  wr_lat_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
    S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer timing");
  wr_block_a: assert property (S_AXI_BVALID |->
    !S_AXI_AWREADY && !S_AXI_WREADY) else $error("ready during response");
  b_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY
    |=> !S_AXI_BVALID ##1 S_AXI_AWREADY) else $error("write not released");

  cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
  cover property (S_AXI_RVALID && S_AXI_RREADY);
  cover property (live && pol1 && OUT_CHAN_1);
endmodule

bind ossm_top ossm_top_monitor u_mon (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .STATUS_SRC(STATUS_SRC),
  .OUT_CHAN_1(OUT_CHAN_1));

`default_nettype wire

// *** verif/ossm_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module ossm_tb_top;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid;
  logic        arvalid, arready, rvalid, bready, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, rnd;
  logic [1:0]  bresp, rresp, r;
  logic [9:0]  src;
  logic [3:0]  lvl, act;
  logic [21:0] cfg;
  int          num_errors, n_compared;
  // corner set: {mode, polarity, select}
  logic [21:0] cor [4] = '{22'h0f2220, 22'h150220, 22'h11fa01, 22'h1a5110};

  ossm_top i_ossm_top (
    .CLOCK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .STATUS_SRC(src),
    .OUT_CHAN_1(lvl[0]), .OUT_CHAN_2(lvl[1]), .OUT_CHAN_3(lvl[2]),
    .OUT_CHAN_4(lvl[3]));

  ossm_upper_model i_ossm_upper_model (
    .level(lvl), .pol(cfg[19:16]), .active(act));

  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction

  // a higher channel on the index pulse silences the lower ones
  function automatic logic [3:0] exp_lvl(input logic [9:0] s,
                                         input logic [21:0] c);
    logic [9:0] g;
    logic [3:0] o, k;
    logic       a;
    g = s;
    g[1] = g[1] && c[21:20] == 2'h0;
    g[5] = g[5] && c[21:20] == 2'h1;
    o[0] = g[0] ^ c[16];
    for (int n = 1; n < 4; n++) begin
      k = c[n*4 +: 4];
      a = (k > 4'h0 && k < 4'ha) ? g[k] : 1'b0;
      for (int m = n + 1; m < 4; m++) begin
        if (k == 4'h2 && c[m*4 +: 4] == 4'h2) a = 1'b0;
      end
      o[n] = (k == 4'h2) ? ~a : ~(a ^ c[16+n]);
    end
    return o;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    // ready follows valid by one edge so the hold path gets exercised
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  // sources change every other edge so each level is seen settled
  task automatic sample;
    repeat (6) begin
      @(posedge clk);
      rnd = lfsr(rnd);
      src <= rnd[9:0];
      @(posedge clk);
      #1;
      chk(lvl, exp_lvl(src, cfg));
      chk(act[0], src[0]);
    end
  endtask

  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test;
  end

  initial begin
    {rst, awvalid, wvalid, arvalid, bready, rready} = 6'h20;
    {awaddr, araddr, wdata, src} = '0;
    rnd = 32'h99ce1293;
    cfg = 22'h003210;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    {awvalid, wvalid, arvalid} <= 3'h0;
    rd(ossm_pkg::OFS_SELECT);
    chk(d, 32'h00003210);
    rd(ossm_pkg::OFS_POLARITY);
    chk(d, 32'h0);
    sample();
    rd(8'h40);
    chk(r, ossm_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h40, 32'hffffffff);
    chk(r, ossm_pkg::RESP_SLVERR);
    for (int i = 0; i < 36; i++) begin
      rnd = lfsr(rnd);
      cfg = (i < 4) ? cor[i] : rnd[21:0];
      wr(ossm_pkg::OFS_SELECT, {16'h0, cfg[15:0]});
      chk(r, ossm_pkg::RESP_OKAY);
      wr(ossm_pkg::OFS_POLARITY, {28'h0, cfg[19:16]});
      wr(ossm_pkg::OFS_MODE, {30'h0, cfg[21:20]});
      rd(ossm_pkg::OFS_SELECT);
      chk(d, {16'h0, cfg[15:4], 4'h0});
      sample();
      rd(ossm_pkg::OFS_LEVEL);
      chk(d[3:0], exp_lvl(src, cfg));
      chk(d[13:4], src & ~{4'h0, (cfg[21:20] != 2'h1), 3'h0,
                          (cfg[21:20] != 2'h0), 1'b0});
    end
    finish_test;
  end
endmodule

`default_nettype wire
